/* File: tcis_pkg.sv */
package tcis_pkg;

    // Byte framing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;

    // Address byte layout
    localparam int ADDR_W = 7;
    localparam int STRAP_W = 2;
    localparam int PREFIX_MSB = 7;
    localparam int PREFIX_LSB = 3;
    localparam int STRAP_MSB = 2;
    localparam int STRAP_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic [4:0] ADDR_PREFIX = 5'h12;
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    localparam logic DIR_READ = 1'h1;

    // Master bit timing
    localparam int SYS_CLK_NS = 50;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QTR_CYC = SCL_PERIOD_NS / 4 / SYS_CLK_NS;

    // Bit phases within one SCL period
    localparam logic [1:0] PH_SETUP = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    typedef enum logic [5:0] {
        TCIS_S_IDLE = 6'h01,
        TCIS_S_RX = 6'h02,
        TCIS_S_ACK = 6'h04,
        TCIS_S_TX = 6'h08,
        TCIS_S_MACK = 6'h10,
        TCIS_S_IGNORE = 6'h20
    } tcis_sst_t;

    typedef enum logic [3:0] {
        TCIS_M_IDLE = 4'h1,
        TCIS_M_START = 4'h2,
        TCIS_M_BYTE = 4'h4,
        TCIS_M_STOP = 4'h8
    } tcis_mst_t;

    typedef enum logic [1:0] {
        TCIS_CMD_START = 2'h0,
        TCIS_CMD_WRITE = 2'h1,
        TCIS_CMD_READ = 2'h2,
        TCIS_CMD_STOP = 2'h3
    } tcis_cmd_t;

endpackage

/* File: tcis_bus_if.sv */
interface tcis_bus_if;
    // Open-drain drives of each end
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    // Resolved wire levels, pulled up when nobody drives low
    logic scl;
    logic sda;

    assign scl = (scl_m_oe && !scl_m_o) ? 1'h0 : 1'h1;
    assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'h0 : 1'h1;

    modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
                    input scl, input sda);
    modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

/* File: tcis_master.sv */
module tcis_master #(
    parameter int QTR_CYC = tcis_pkg::SCL_QTR_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Two-wire bus
    tcis_bus_if.master bus,
    // Command port
    input wire logic cmd_valid,
    input wire tcis_pkg::tcis_cmd_t cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_ack,
    output logic cmd_ready,
    // Response port
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    output logic bus_busy
);
    import tcis_pkg::*;

    tcis_mst_t st_q;
    logic [15:0] qcnt_q;
    logic [1:0] phase_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic rd_q;
    logic ack_q;
    logic scl_q;
    logic sda_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic rsp_nack_q;
    logic busy_q;

    wire tick = (qcnt_q == 16'(QTR_CYC - 1));
    wire last_bit = (bit_q == BIT_CNT_FULL);
    wire take = cmd_valid && (st_q == TCIS_M_IDLE);

    // Open-drain: only ever drive low
    assign bus.scl_m_o = 1'h0;
    assign bus.sda_m_o = 1'h0;
    assign bus.scl_m_oe = !scl_q;
    assign bus.sda_m_oe = !sda_q;
    assign cmd_ready = (st_q == TCIS_M_IDLE);
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_nack = rsp_nack_q;
    assign bus_busy = busy_q;

    always_ff @(posedge sys_clk) begin
        sda_s1_q <= bus.sda;
        sda_s2_q <= sda_s1_q;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= TCIS_M_IDLE;
            qcnt_q <= '0;
            phase_q <= PH_SETUP;
            bit_q <= '0;
            sh_q <= '0;
            rd_q <= 1'h0;
            ack_q <= 1'h0;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            rsp_valid_q <= 1'h0;
            rsp_data_q <= '0;
            rsp_nack_q <= 1'h0;
            busy_q <= 1'h0;
        end else begin
            rsp_valid_q <= 1'h0;
            qcnt_q <= (st_q == TCIS_M_IDLE || tick) ? '0 : qcnt_q + 16'h1;
            if (st_q != TCIS_M_IDLE && tick) begin
                phase_q <= phase_q + 2'h1;
            end
            case (st_q)
                TCIS_M_IDLE: begin
                    phase_q <= PH_SETUP;
                    bit_q <= '0;
                    if (take) begin
                        sh_q <= cmd_wdata;
                        rd_q <= (cmd_code == TCIS_CMD_READ);
                        ack_q <= cmd_ack;
                        case (cmd_code)
                            TCIS_CMD_START: st_q <= TCIS_M_START;
                            TCIS_CMD_STOP: st_q <= TCIS_M_STOP;
                            default: st_q <= TCIS_M_BYTE;
                        endcase
                    end
                end
                // START or repeated START: SDA falls while SCL high
                TCIS_M_START: if (tick) begin
                    case (phase_q)
                        PH_SETUP: sda_q <= 1'h1;
                        PH_RISE: scl_q <= 1'h1;
                        PH_HIGH: sda_q <= 1'h0;
                        default: begin
                            scl_q <= 1'h0;
                            busy_q <= 1'h1;
                            st_q <= TCIS_M_IDLE;
                        end
                    endcase
                end
                // Nine clocks per byte, ninth carries acknowledge
                TCIS_M_BYTE: if (tick) begin
                    case (phase_q)
                        PH_SETUP: begin
                            if (!last_bit) begin
                                sda_q <= rd_q ? 1'h1 : sh_q[7];
                            end else begin
                                sda_q <= rd_q ? !ack_q : 1'h1;
                            end
                        end
                        PH_RISE: scl_q <= 1'h1;
                        PH_HIGH: begin
                            if (!last_bit) begin
                                sh_q <= {sh_q[6:0], sda_s2_q};
                            end else begin
                                rsp_nack_q <= sda_s2_q;
                            end
                        end
                        default: begin
                            scl_q <= 1'h0;
                            if (last_bit) begin
                                rsp_valid_q <= 1'h1;
                                rsp_data_q <= sh_q;
                                st_q <= TCIS_M_IDLE;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    endcase
                end
                // STOP: SDA rises while SCL high
                TCIS_M_STOP: if (tick) begin
                    case (phase_q)
                        PH_SETUP: sda_q <= 1'h0;
                        PH_RISE: scl_q <= 1'h1;
                        PH_HIGH: sda_q <= 1'h1;
                        default: begin
                            busy_q <= 1'h0;
                            st_q <= TCIS_M_IDLE;
                        end
                    endcase
                end
                default: st_q <= TCIS_M_IDLE;
            endcase
        end
    end
endmodule

/* File: tcis_slave.sv */
// Summary of operation
// - Receiver acknowledges each byte; master adds ninth clock
// - Acknowledge holds SDA low through clock high
// - Master not-acknowledge: device releases SDA
// - Write: acknowledge address and every data byte
// - Master acknowledges read bytes except the last
// - Master clocks; repeated START opens new transfer
// - Detect START/STOP, compare address after direction bit
// - Read: device drives SDA on master clock
// - SDA changes only while SCL low
// - Eight data bits plus acknowledge: nine clocks
// - High-speed entry: START, 00001xxx, not-acknowledge
// - Never acknowledge or match a master code
// - After master code, addressed device acknowledges normally
// - High-speed persists across repeated STARTs until STOP
// - Address is 10010 plus two strap bits
// - Straps sampled once after reset only
// - Address latched on SCL fall after direction
// - Direction bit one reads, zero writes
// - Acknowledge when prefix, straps and direction received
// - After STOP the bus is free
// - Any number of data bytes is accepted
module tcis_slave (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    // Two-wire bus
    tcis_bus_if.slave bus,
    // Address straps
    input wire logic addr_select_pin_hi,
    input wire logic addr_select_pin_lo,
    // Transmit data for reads
    input wire logic tx_load,
    input wire logic [7:0] tx_data,
    output logic tx_req,
    // Received data and status
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic addressed,
    output logic hs_mode,
    output logic [tcis_pkg::ADDR_W-1:0] slave_addr
);
    import tcis_pkg::*;

    // Link-domain reset, carried over from the system clock
    logic lrst_q1, lrst_q2;
    // Pin synchronisers and edge history
    logic scl_q1, scl_q2, scl_q3;
    logic sda_q1, sda_q2, sda_q3;
    logic strap_hi_q1, strap_hi_q2, strap_lo_q1, strap_lo_q2;
    logic strap_done_q;
    logic [STRAP_W-1:0] own_strap_q;
    // Protocol state
    tcis_sst_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, rx_byte_q, tx_word_q;
    logic addr_phase_q, dir_rd_q, mack_q, hs_q;
    logic [ADDR_W-1:0] addr_q;
    logic rx_tgl_q, txr_tgl_q, adr_lnk_q;
    // Crossings into the link domain
    logic txl_q1, txl_q2, txl_q3;
    // System-domain side
    logic [7:0] tx_hold_q, rx_data_q;
    logic tx_tgl_q, rxs_q1, rxs_q2, rxs_q3;
    logic txr_q1, txr_q2, txr_q3;
    logic hs_s1_q, hs_s2_q, adr_s1_q, adr_s2_q;
    logic rx_valid_q, tx_req_q;
    logic [ADDR_W-1:0] addr_out_q;

    wire link_rst = lrst_q2;
    wire scl_rise = scl_q2 && !scl_q3;
    wire scl_fall = !scl_q2 && scl_q3;
    wire start_c = scl_q2 && scl_q3 && !sda_q2 && sda_q3;
    wire stop_c = scl_q2 && scl_q3 && sda_q2 && !sda_q3;
    wire byte_done = (bit_q == BIT_CNT_FULL);
    wire [4:0] rx_prefix = sh_q[PREFIX_MSB:PREFIX_LSB];
    wire [STRAP_W-1:0] rx_strap = sh_q[STRAP_MSB:STRAP_LSB];
    wire addr_match = (rx_prefix == ADDR_PREFIX) && (rx_strap == own_strap_q);
    wire is_mcode = (rx_prefix == MCODE_PREFIX);
    wire tx_new = txl_q2 ^ txl_q3;
    wire link_addressed = !addr_phase_q && (st_q != TCIS_S_IDLE) && (st_q != TCIS_S_IGNORE);

    // Open-drain SDA: low during acknowledge or a zero data bit
    assign bus.sda_s_o = 1'h0;
    assign bus.sda_s_oe = (st_q == TCIS_S_ACK) || ((st_q == TCIS_S_TX) && !sh_q[7]);

    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;
    assign tx_req = tx_req_q;
    assign hs_mode = hs_s2_q;
    assign addressed = adr_s2_q;
    assign slave_addr = addr_out_q;

    // Link domain: synchronisers
    always_ff @(posedge link_clk) begin
        lrst_q1 <= sys_rst;
        lrst_q2 <= lrst_q1;
        scl_q1 <= bus.scl;
        scl_q2 <= scl_q1;
        scl_q3 <= scl_q2;
        sda_q1 <= bus.sda;
        sda_q2 <= sda_q1;
        sda_q3 <= sda_q2;
        strap_hi_q1 <= addr_select_pin_hi;
        strap_hi_q2 <= strap_hi_q1;
        strap_lo_q1 <= addr_select_pin_lo;
        strap_lo_q2 <= strap_lo_q1;
        txl_q1 <= tx_tgl_q;
        txl_q2 <= txl_q1;
        txl_q3 <= txl_q2;
        // Registered so no decode glitch reaches the system-side synchroniser
        adr_lnk_q <= link_addressed;
    end

    // Straps caught once on the first cycle after reset release
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            strap_done_q <= 1'h0;
            own_strap_q <= '0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'h1;
            own_strap_q <= {strap_hi_q2, strap_lo_q2};
        end
    end

    // Next transmit byte, handed over from the system clock
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            tx_word_q <= '0;
        end else if (tx_new) begin
            tx_word_q <= tx_hold_q;
        end
    end

    // Link domain: protocol engine
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            st_q <= TCIS_S_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            addr_phase_q <= 1'h0;
            dir_rd_q <= 1'h0;
            mack_q <= 1'h0;
            hs_q <= 1'h0;
            addr_q <= '0;
            rx_byte_q <= '0;
            rx_tgl_q <= 1'h0;
            txr_tgl_q <= 1'h0;
        end else if (start_c) begin
            st_q <= TCIS_S_RX;
            bit_q <= '0;
            addr_phase_q <= 1'h1;
        end else if (stop_c) begin
            st_q <= TCIS_S_IDLE;
            hs_q <= 1'h0;
            addr_phase_q <= 1'h0;
        end else begin
            case (st_q)
                TCIS_S_RX: begin
                    if (scl_rise && !byte_done) begin
                        sh_q <= {sh_q[6:0], sda_q2};
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_q <= '0;
                        if (addr_phase_q) begin
                            addr_phase_q <= 1'h0;
                            if (addr_match) begin
                                addr_q <= sh_q[PREFIX_MSB:STRAP_LSB];
                                dir_rd_q <= (sh_q[DIR_BIT] == DIR_READ);
                                st_q <= TCIS_S_ACK;
                            end else begin
                                hs_q <= hs_q || is_mcode;
                                st_q <= TCIS_S_IGNORE;
                            end
                        end else begin
                            rx_byte_q <= sh_q;
                            rx_tgl_q <= !rx_tgl_q;
                            st_q <= TCIS_S_ACK;
                        end
                    end
                end
                // Release on the falling edge ending the acknowledge clock
                TCIS_S_ACK: begin
                    if (scl_fall) begin
                        bit_q <= '0;
                        if (dir_rd_q) begin
                            sh_q <= tx_word_q;
                            txr_tgl_q <= !txr_tgl_q;
                            st_q <= TCIS_S_TX;
                        end else begin
                            st_q <= TCIS_S_RX;
                        end
                    end
                end
                TCIS_S_TX: begin
                    if (scl_rise) begin
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            st_q <= TCIS_S_MACK;
                            bit_q <= '0;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'h1};
                        end
                    end
                end
                TCIS_S_MACK: begin
                    if (scl_rise) begin
                        mack_q <= !sda_q2;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            sh_q <= tx_word_q;
                            txr_tgl_q <= !txr_tgl_q;
                            st_q <= TCIS_S_TX;
                        end else begin
                            st_q <= TCIS_S_IGNORE;
                        end
                    end
                end
                TCIS_S_IDLE: st_q <= TCIS_S_IDLE;
                TCIS_S_IGNORE: st_q <= TCIS_S_IGNORE;
                default: st_q <= TCIS_S_IDLE;
            endcase
        end
    end

    // System domain: transmit byte hold and hand-over toggle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_hold_q <= '0;
            tx_tgl_q <= 1'h0;
        end else if (tx_load) begin
            tx_hold_q <= tx_data;
            tx_tgl_q <= !tx_tgl_q;
        end
    end

    // System domain: synchronisers from the link
    always_ff @(posedge sys_clk) begin
        rxs_q1 <= rx_tgl_q;
        rxs_q2 <= rxs_q1;
        rxs_q3 <= rxs_q2;
        txr_q1 <= txr_tgl_q;
        txr_q2 <= txr_q1;
        txr_q3 <= txr_q2;
        hs_s1_q <= hs_q;
        hs_s2_q <= hs_s1_q;
        adr_s1_q <= adr_lnk_q;
        adr_s2_q <= adr_s1_q;
    end

    // Received byte and address words are stable for a whole byte time when read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_valid_q <= 1'h0;
            rx_data_q <= '0;
            tx_req_q <= 1'h0;
            addr_out_q <= '0;
        end else begin
            rx_valid_q <= rxs_q2 ^ rxs_q3;
            tx_req_q <= txr_q2 ^ txr_q3;
            if (rxs_q2 ^ rxs_q3) begin
                rx_data_q <= rx_byte_q;
            end
            if (adr_s2_q) begin
                addr_out_q <= addr_q;
            end
        end
    end
endmodule

/* File: tcis_bus_properties.sv */
module tcis_bus_properties #(
    parameter logic [1:0] STRAP = 2'h0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Bus wires
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    import tcis_pkg::*;
    logic scl_q, sda_q, first_q, rd_q, wr_q, nak_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire start_c = scl && scl_q && sda_q && !sda;
    wire stop_c = scl && scl_q && !sda_q && sda;
    wire bound_c = start_c || stop_c;
    wire ack_rise = scl_rise && (cnt_q == BIT_CNT_FULL);
    wire [3:0] cnt_nx = (cnt_q == BIT_CNT_FULL) ? 4'h0 : cnt_q + 4'h1;
    wire match = (sh_q[7:1] == {ADDR_PREFIX, STRAP});
    wire exp_ack = first_q ? match : wr_q;
    wire nak_c = ack_rise && rd_q && !first_q && sda;
    wire rd_data = rd_q && !first_q;

    always_ff @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || bound_c) begin
            cnt_q <= 4'h0;
        end else if (scl_rise) begin
            cnt_q <= cnt_nx;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (scl_rise && !ack_rise) begin
            sh_q <= {sh_q[6:0], sda};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || stop_c || ack_rise) begin
            first_q <= 1'h0;
        end else if (start_c) begin
            first_q <= 1'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || bound_c || nak_c) begin
            rd_q <= 1'h0;
        end else if (ack_rise && first_q) begin
            rd_q <= match && (sh_q[DIR_BIT] == DIR_READ);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || bound_c) begin
            wr_q <= 1'h0;
        end else if (ack_rise && first_q) begin
            wr_q <= match && (sh_q[DIR_BIT] != DIR_READ);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || bound_c) begin
            nak_q <= 1'h0;
        end else if (nak_c) begin
            nak_q <= 1'h1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_ack_when_due: assert property (ack_rise && exp_ack |-> sda_s_oe)
        else $error("expected acknowledge missing");
    a_no_ack_other: assert property (ack_rise && !exp_ack |-> !sda_s_oe)
        else $error("acknowledge driven when none allowed");
    a_ack_held_high: assert property (ack_rise && exp_ack |-> sda_s_oe [*6])
        else $error("acknowledge dropped during clock high");
    a_ack_prompt: assert property (scl_fall && cnt_q == 4'h8 && exp_ack |-> ##[1:8] sda_s_oe)
        else $error("acknowledge not driven after eighth bit");
    a_oe_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave data changed while clock high");
    a_release_nack: assert property (nak_q |-> !sda_s_oe)
        else $error("slave drives after master not-acknowledge");
    a_quiet_no_read: assert property (scl_rise && cnt_q < 4'h8 && !rd_data |-> !sda_s_oe)
        else $error("slave drives a bit outside a read");
    a_cond_quiet: assert property (bound_c |-> !sda_s_oe && !sda_s_o)
        else $error("slave drives at a start or stop");

    c_write_ack: cover property (ack_rise && wr_q && !first_q && !sda);
    c_read_nack: cover property (nak_c);
    c_mcode_seen: cover property (ack_rise && first_q && sh_q[7:3] == MCODE_PREFIX);
endmodule

/* File: touch_ctrl_i2c_slave_port_tb.sv */
module touch_ctrl_i2c_slave_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcis_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic na; logic nd; logic rx;} tcis_row_t;
    logic sys_clk = 1'h0;
    logic link_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_ack = 1'h0;
    tcis_cmd_t cmd_code = TCIS_CMD_START;
    logic [7:0] cmd_wdata = 8'h00;
    logic addr_select_pin_hi = 1'h1;
    logic addr_select_pin_lo = 1'h0;
    logic tx_load = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_nack, bus_busy, tx_req, rx_valid, addressed, hs_mode;
    logic [7:0] rsp_data, rx_data;
    logic [6:0] slave_addr;
    logic [7:0] rxq[$];
    int error_cnt = 0;
    int tests_run = 0;
    int txreq_cnt = 0;
    tcis_row_t rows[5] = '{'{8'h94, 8'h3C, 0, 0, 1}, '{8'h96, 8'h11, 1, 1, 0},
        '{8'h90, 8'h22, 1, 1, 0}, '{8'hA4, 8'h33, 1, 1, 0}, '{8'h09, 8'h44, 1, 1, 0}};

    always #25 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    tcis_bus_if bus_if();
    tcis_master #(.QTR_CYC(4)) u_tcis_master (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus_busy(bus_busy));
    tcis_slave u_tcis_slave (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .bus(bus_if), .addr_select_pin_hi(addr_select_pin_hi),
        .addr_select_pin_lo(addr_select_pin_lo), .tx_load(tx_load), .tx_data(tx_data),
        .tx_req(tx_req), .rx_valid(rx_valid), .rx_data(rx_data), .addressed(addressed),
        .hs_mode(hs_mode), .slave_addr(slave_addr));
    tcis_bus_properties #(.STRAP(2'h2)) u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl),
        .sda(bus_if.sda));

    // Collect slave-side pulses
    always @(posedge sys_clk) begin
        if (rx_valid === 1'h1) rxq.push_back(rx_data);
        if (tx_req === 1'h1) txreq_cnt++;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmd(input tcis_cmd_t c, input logic [7:0] d, input logic a);
        int n;
        logic byt;
        n = 0;
        byt = (c == TCIS_CMD_WRITE) || (c == TCIS_CMD_READ);
        @(posedge sys_clk);
        cmd_valid <= 1'h1;
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_ack <= a;
        @(posedge sys_clk);
        while (cmd_ready !== 1'h1 && n < 400) begin
            n++;
            @(posedge sys_clk);
        end
        cmd_valid <= 1'h0;
        @(posedge sys_clk);
        while ((byt ? rsp_valid : cmd_ready) !== 1'h1 && n < 400) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 400) chk(8'hEE, 8'h00);
    endtask

    task automatic stop_chk(input int cnt);
        cmd(TCIS_CMD_STOP, 8'h00, 1'h0);
        repeat (10) @(posedge sys_clk);
        chk(addressed, 1'h0);
        chk(bus_busy, 1'h0);
        chk(8'(rxq.size()), 8'(cnt));
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        chk(cmd_ready, 1'h1);
        chk({bus_busy, bus_if.sda_s_oe, addressed, hs_mode}, 8'h00);
        sys_rst <= 1'h0;
        repeat (10) @(posedge sys_clk);
        chk({bus_if.scl, bus_if.sda}, 8'h03);
        foreach (rows[i]) begin
            cmd(TCIS_CMD_START, 8'h00, 1'h0);
            chk(bus_busy, 1'h1);
            cmd(TCIS_CMD_WRITE, rows[i].a, 1'h0);
            chk(rsp_nack, rows[i].na);
            chk(rsp_data, rows[i].a);
            cmd(TCIS_CMD_WRITE, rows[i].d, 1'h0);
            chk(rsp_nack, rows[i].nd);
            stop_chk(rows[i].rx);
            if (rxq.size() > 0) chk(rxq.pop_front(), rows[i].d);
            rxq.delete();
        end
        chk(slave_addr, 7'h4A);
        // Master code, then chained transfers over repeated starts
        cmd(TCIS_CMD_START, 8'h00, 1'h0);
        cmd(TCIS_CMD_WRITE, 8'h09, 1'h0);
        chk(rsp_nack, 1'h1);
        for (int k = 0; k < 2; k++) begin
            cmd(TCIS_CMD_START, 8'h00, 1'h0);
            cmd(TCIS_CMD_WRITE, 8'h94, 1'h0);
            chk(rsp_nack, 1'h0);
            chk(hs_mode, 1'h1);
            for (int j = 0; j < 3; j++) begin
                cmd(TCIS_CMD_WRITE, 8'h5A + 8'(j), 1'h0);
                chk(rsp_nack, 1'h0);
            end
        end
        stop_chk(6);
        chk(hs_mode, 1'h0);
        for (int j = 0; j < 6; j++) chk(rxq.pop_front(), 8'h5A + 8'(j % 3));
        // Late strap change must not move the address
        addr_select_pin_lo <= 1'h1;
        tx_data <= 8'hA5;
        tx_load <= 1'h1;
        @(posedge sys_clk);
        tx_load <= 1'h0;
        txreq_cnt = 0;
        cmd(TCIS_CMD_START, 8'h00, 1'h0);
        cmd(TCIS_CMD_WRITE, 8'h95, 1'h0);
        chk(rsp_nack, 1'h0);
        cmd(TCIS_CMD_READ, 8'h00, 1'h1);
        chk(rsp_data, 8'hA5);
        chk(addressed, 1'h1);
        cmd(TCIS_CMD_READ, 8'h00, 1'h0);
        chk(rsp_data, 8'hA5);
        chk(rsp_nack, 1'h1);
        stop_chk(0);
        chk(txreq_cnt >= 2, 1'h1);
        conclude();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
endmodule
